//--- tumh_regs.vh
// What this block does
// - Telephone user messages carry service indicator 0100 and are routed here.
// - National indicator 00 is international, 10 national; 01 and 11 not accepted.
// - The two spare bits of the service octet are sent as 00.
// - Signalling information is whole octets: label, heading code, signals.
// - Service indicator is looked at only for message signal units.
// - Missing mandatory subfields are treated as a format error.
// - Report address-incomplete on end-of-address or digit timeout with too few digits.
// - After clear-forward, or reset-circuit in release mode, idle the circuit, then send release-guard.
// - Reset-circuit on a locally blocked circuit releases it and clears the block unless in block reply mode.
// - Received blocking engages outgoing use; incoming allowed unless blocked locally.
// - Received unblocking cancels the engaged condition set by blocking.
// - After blocking on a received blocking signal, send blocking-acknowledgment.
// - After unblocking on a received unblocking signal, send unblocking-acknowledgment.
// - Automatic working: charge answer starts metering and duration measurement.
// - Automatic working: no-charge answer never starts metering.
// - Sending clear-forward ends the call and releases the circuit; also reset reply.
// - Send subscriber-busy when busy location unknown or not told from congestion.
// - Record charging decision of address-complete; coin-box also marks coin station.
// - Reset-circuit may be answered with a blocking signal instead of release.
// - Every spare bit is sent as zero.
// - Each subfield is serialised least significant bit first.
`ifndef TUMH_REGS_VH
`define TUMH_REGS_VH

// Service information octet
`define TUMH_SI_TUP        4'h4
`define TUMH_NI_INTL       2'h0
`define TUMH_NI_NATL       2'h2
`define TUMH_SPARE_VAL     2'h0
`define TUMH_SIO_SI_LSB    0
`define TUMH_SIO_SP_LSB    4
`define TUMH_SIO_NI_LSB    6

// Signal codes
`define TUMH_SIG_NONE      8'h00
`define TUMH_SIG_ACM       8'h01
`define TUMH_SIG_ACM_CHG   8'h02
`define TUMH_SIG_ACM_NOCHG 8'h03
`define TUMH_SIG_ACM_COIN  8'h04
`define TUMH_SIG_ANS_CHG   8'h05
`define TUMH_SIG_ANS_NOCHG 8'h06
`define TUMH_SIG_CLF       8'h07
`define TUMH_SIG_RLG       8'h08
`define TUMH_SIG_RSC       8'h09
`define TUMH_SIG_BLO       8'h0a
`define TUMH_SIG_UBL       8'h0b
`define TUMH_SIG_BLA       8'h0c
`define TUMH_SIG_UBA       8'h0d
`define TUMH_SIG_DIGIT     8'h0e
`define TUMH_SIG_EOA       8'h0f
`define TUMH_SIG_ADI       8'h10
`define TUMH_SIG_SSB       8'h11
`define TUMH_SIG_NNC       8'h12

// Local commands
`define TUMH_CMD_BLOCK     2'h0
`define TUMH_CMD_UNBLOCK   2'h1
`define TUMH_CMD_CLEAR     2'h2
`define TUMH_CMD_FAIL      2'h3

// Failure causes
`define TUMH_CAUSE_BUSY    2'h0
`define TUMH_CAUSE_UNKNOWN 2'h1
`define TUMH_CAUSE_NODISC  2'h2
`define TUMH_CAUSE_NATCONG 2'h3

// Reset-circuit reply modes
`define TUMH_RSC_RELEASE   2'h0
`define TUMH_RSC_CLEAR     2'h1
`define TUMH_RSC_BLOCK     2'h2

// Register map
`define TUMH_REG_CTRL      2'h0
`define TUMH_REG_STATUS    2'h1
`define TUMH_REG_COUNT     2'h2
`define TUMH_CTRL_RESET    8'h34
`define TUMH_CTRL_NI_LSB   0
`define TUMH_CTRL_RSC_LSB  2
`define TUMH_CTRL_AUTO     4
`define TUMH_CTRL_MIN_LSB  5

// Timing
`define TUMH_CLK_MHZ       25
`define TUMH_DIGIT_TO_US   20000
`define TUMH_SER_BITS      16

`endif

//--- tumh_msg_handler.v
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "tumh_regs.vh"

module tumh_msg_handler #(
	parameter NCIRC        = 32,
	parameter CW           = 5,
	parameter DIGIT_TO_CYC = `TUMH_DIGIT_TO_US * `TUMH_CLK_MHZ
) (
	input  wire          SYS_CLK_I,
	input  wire          RST_N_I,
	input  wire [1:0]    REG_ADDR_I,
	input  wire [7:0]    REG_WDATA_I,
	input  wire          REG_WR_I,
	input  wire          REG_RD_I,
	output reg  [7:0]    REG_RDATA_O,
	input  wire          RX_VALID_I,
	output wire          RX_READY_O,
	input  wire          RX_MSU_I,
	input  wire [7:0]    RX_SIO_I,
	input  wire [7:0]    RX_SIGNAL_I,
	input  wire [CW-1:0] RX_CIRCUIT_I,
	input  wire          RX_OCTETS_OK_I,
	input  wire          RX_MAND_OK_I,
	input  wire          CMD_VALID_I,
	output wire          CMD_READY_O,
	input  wire [1:0]    CMD_CODE_I,
	input  wire [1:0]    CMD_CAUSE_I,
	input  wire [CW-1:0] CMD_CIRCUIT_I,
	output reg           TX_VALID_O,
	output reg  [7:0]    TX_SIO_O,
	output reg  [7:0]    TX_SIGNAL_O,
	output reg  [CW-1:0] TX_CIRCUIT_O,
	output reg           TX_SER_O,
	output reg           TX_SER_VALID_O,
	input  wire [CW-1:0] QRY_CIRCUIT_I,
	output reg           QRY_OUT_FREE_O,
	output reg           QRY_IN_OK_O,
	output reg           QRY_IDLE_O,
	output reg           METER_START_O,
	output reg           DURATION_START_O,
	output reg  [1:0]    CHARGE_REC_O,
	output reg           COIN_STATION_O
);

	localparam [23:0] TO_CYC = DIGIT_TO_CYC[23:0];
	localparam [4:0]  SER_N  = `TUMH_SER_BITS;

	// Control and state
	reg  [7:0]       ctrl;
	reg  [7:0]       disc_cnt;
	reg  [7:0]       fmt_cnt;
	reg  [3:0]       digit_cnt;
	reg  [23:0]      digit_tmr;
	reg  [CW-1:0]    digit_circ;
	reg              resp_pend;
	reg  [7:0]       resp_sig;
	reg  [CW-1:0]    resp_circ;
	reg  [15:0]      ser_shift;
	reg  [4:0]       ser_left;
	reg  [NCIRC-1:0] loc_blk;
	reg  [NCIRC-1:0] rem_blk;
	reg  [NCIRC-1:0] idle;

	wire [1:0] ni_cfg   = ctrl[`TUMH_CTRL_NI_LSB +: 2];
	wire [1:0] rsc_mode = ctrl[`TUMH_CTRL_RSC_LSB +: 2];
	wire       auto_wk  = ctrl[`TUMH_CTRL_AUTO];
	wire [2:0] min_dig  = ctrl[`TUMH_CTRL_MIN_LSB +: 3];

	// Receive classification
	wire [3:0] rx_si    = RX_SIO_I[`TUMH_SIO_SI_LSB +: 4];
	wire [1:0] rx_sp    = RX_SIO_I[`TUMH_SIO_SP_LSB +: 2];
	wire [1:0] rx_ni    = RX_SIO_I[`TUMH_SIO_NI_LSB +: 2];
	wire       tmr_fire = (digit_tmr == 24'h000001);
	wire       ser_busy = (ser_left != 5'h00);
	wire       rx_take  = RX_VALID_I && RX_READY_O;
	wire       rx_msu   = rx_take && RX_MSU_I;
	wire       si_ok    = (rx_si == `TUMH_SI_TUP);
	wire       ni_ok    = (rx_ni == `TUMH_NI_INTL) || (rx_ni == `TUMH_NI_NATL);
	wire       fmt_ok   = RX_OCTETS_OK_I && RX_MAND_OK_I && (rx_sp == `TUMH_SPARE_VAL);
	wire       seize_bad = (RX_SIGNAL_I == `TUMH_SIG_DIGIT) && loc_blk[RX_CIRCUIT_I];
	wire       rx_acc   = rx_msu && si_ok && ni_ok && fmt_ok && !seize_bad;
	wire       rx_disc  = rx_msu && (!si_ok || !ni_ok || seize_bad);
	wire       rx_fmt   = rx_msu && si_ok && ni_ok && !fmt_ok;

	// Handshakes: stall while a reply waits or the timer is due
	assign RX_READY_O  = !resp_pend && !tmr_fire;
	assign CMD_READY_O = !resp_pend && !tmr_fire && !ser_busy && !RX_VALID_I;

	wire cmd_take = CMD_VALID_I && CMD_READY_O;

	// Decoded events
	wire ev_clf  = rx_acc && (RX_SIGNAL_I == `TUMH_SIG_CLF);
	wire ev_rsc  = rx_acc && (RX_SIGNAL_I == `TUMH_SIG_RSC);
	wire ev_blo  = rx_acc && (RX_SIGNAL_I == `TUMH_SIG_BLO);
	wire ev_ubl  = rx_acc && (RX_SIGNAL_I == `TUMH_SIG_UBL);
	wire ev_dig  = rx_acc && (RX_SIGNAL_I == `TUMH_SIG_DIGIT);
	wire ev_eoa  = rx_acc && (RX_SIGNAL_I == `TUMH_SIG_EOA);
	wire c_blk   = cmd_take && (CMD_CODE_I == `TUMH_CMD_BLOCK);
	wire c_ubl   = cmd_take && (CMD_CODE_I == `TUMH_CMD_UNBLOCK);
	wire c_clr   = cmd_take && (CMD_CODE_I == `TUMH_CMD_CLEAR);
	wire c_fail  = cmd_take && (CMD_CODE_I == `TUMH_CMD_FAIL);
	wire rsc_blk = ev_rsc && (rsc_mode == `TUMH_RSC_BLOCK);
	wire short_addr = ({1'b0, digit_cnt} < {2'b00, min_dig});

	// Per-circuit supervision flags
	genvar gi;
	generate
		for (gi = 0; gi < NCIRC; gi = gi + 1) begin : g_circ
			localparam [CW-1:0] CIDX = gi;
			wire rx_hit  = (RX_CIRCUIT_I == CIDX);
			wire cmd_hit = (CMD_CIRCUIT_I == CIDX);
			always @(posedge SYS_CLK_I) begin
				if (!RST_N_I) begin
					loc_blk[gi] <= 1'b0;
					rem_blk[gi] <= 1'b0;
					idle[gi]    <= 1'b1;
				end else begin
					// Local block: command, or reset answered by blocking
					if ((c_blk && cmd_hit) || (rsc_blk && rx_hit))
						loc_blk[gi] <= 1'b1;
					else if ((c_ubl && cmd_hit) || (ev_rsc && rx_hit))
						loc_blk[gi] <= 1'b0;
					// Remote block engages outgoing use only
					if (ev_blo && rx_hit)
						rem_blk[gi] <= 1'b1;
					else if (ev_ubl && rx_hit)
						rem_blk[gi] <= 1'b0;
					// Idle on release, busy on seizure
					if ((ev_clf || ev_rsc) && rx_hit)
						idle[gi] <= 1'b1;
					else if (c_clr && cmd_hit)
						idle[gi] <= 1'b1;
					else if (ev_dig && rx_hit)
						idle[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Reply selection for accepted messages and timer expiry
	reg         next_pend;
	reg  [7:0]  next_sig;
	reg [CW-1:0] next_circ;
	always @* begin
		next_pend = 1'b0;
		next_sig  = `TUMH_SIG_NONE;
		next_circ = RX_CIRCUIT_I;
		if (ev_clf) begin
			next_pend = 1'b1;
			next_sig  = `TUMH_SIG_RLG;
		end else if (ev_rsc) begin
			next_pend = 1'b1;
			case (rsc_mode)
				`TUMH_RSC_CLEAR: next_sig = `TUMH_SIG_CLF;
				`TUMH_RSC_BLOCK: next_sig = `TUMH_SIG_BLO;
				default:         next_sig = `TUMH_SIG_RLG;
			endcase
		end else if (ev_blo) begin
			next_pend = 1'b1;
			next_sig  = `TUMH_SIG_BLA;
		end else if (ev_ubl) begin
			next_pend = 1'b1;
			next_sig  = `TUMH_SIG_UBA;
		end else if (ev_eoa && short_addr) begin
			next_pend = 1'b1;
			next_sig  = `TUMH_SIG_ADI;
		end else if (tmr_fire && short_addr) begin
			next_pend = 1'b1;
			next_sig  = `TUMH_SIG_ADI;
			next_circ = digit_circ;
		end
	end

	// Local command to signal code
	reg [7:0] cmd_sig;
	always @* begin
		case (CMD_CODE_I)
			`TUMH_CMD_BLOCK:   cmd_sig = `TUMH_SIG_BLO;
			`TUMH_CMD_UNBLOCK: cmd_sig = `TUMH_SIG_UBL;
			`TUMH_CMD_CLEAR:   cmd_sig = `TUMH_SIG_CLF;
			default: begin
				if (CMD_CAUSE_I == `TUMH_CAUSE_NATCONG)
					cmd_sig = `TUMH_SIG_NNC;
				else
					cmd_sig = `TUMH_SIG_SSB;
			end
		endcase
	end

	// Outgoing service octet, spare bits forced to zero
	wire [7:0] tx_sio = {ni_cfg, `TUMH_SPARE_VAL, `TUMH_SI_TUP};
	wire       send_resp = resp_pend && !ser_busy;
	wire       send_cmd  = cmd_take && !c_fail ? 1'b1 : c_fail;
	wire [7:0] send_sig  = send_resp ? resp_sig : cmd_sig;

	// Reply queue of one entry
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			resp_pend <= 1'b0;
			resp_sig  <= `TUMH_SIG_NONE;
			resp_circ <= {CW{1'b0}};
		end else if (next_pend) begin
			resp_pend <= 1'b1;
			resp_sig  <= next_sig;
			resp_circ <= next_circ;
		end else if (send_resp) begin
			resp_pend <= 1'b0;
		end
	end

	// Transmit word and serialiser
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			TX_VALID_O     <= 1'b0;
			TX_SIO_O       <= 8'h00;
			TX_SIGNAL_O    <= 8'h00;
			TX_CIRCUIT_O   <= {CW{1'b0}};
			TX_SER_O       <= 1'b0;
			TX_SER_VALID_O <= 1'b0;
			ser_shift      <= 16'h0000;
			ser_left       <= 5'h00;
		end else begin
			TX_VALID_O <= send_resp || send_cmd;
			if (send_resp || send_cmd) begin
				TX_SIO_O     <= tx_sio;
				TX_SIGNAL_O  <= send_sig;
				TX_CIRCUIT_O <= send_resp ? resp_circ : CMD_CIRCUIT_I;
				ser_shift    <= {send_sig, tx_sio};
				ser_left     <= SER_N;
			end else if (ser_busy) begin
				ser_shift <= {1'b0, ser_shift[15:1]};
				ser_left  <= ser_left - 5'h01;
			end
			TX_SER_VALID_O <= ser_busy;
			TX_SER_O       <= ser_busy ? ser_shift[0] : 1'b0;
		end
	end

	// Address digit counting and timeout
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			digit_cnt  <= 4'h0;
			digit_tmr  <= 24'h000000;
			digit_circ <= {CW{1'b0}};
		end else if (ev_dig) begin
			if (digit_cnt != 4'hf)
				digit_cnt <= digit_cnt + 4'h1;
			digit_tmr  <= TO_CYC;
			digit_circ <= RX_CIRCUIT_I;
		end else if (ev_eoa || tmr_fire) begin
			digit_cnt <= 4'h0;
			digit_tmr <= 24'h000000;
		end else if (digit_tmr > 24'h000001) begin
			digit_tmr <= digit_tmr - 24'h000001;
		end
	end

	// Call charging outcomes
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			METER_START_O    <= 1'b0;
			DURATION_START_O <= 1'b0;
			CHARGE_REC_O     <= 2'h0;
			COIN_STATION_O   <= 1'b0;
		end else begin
			METER_START_O    <= rx_acc && auto_wk &&
				(RX_SIGNAL_I == `TUMH_SIG_ANS_CHG);
			DURATION_START_O <= rx_acc && auto_wk &&
				(RX_SIGNAL_I == `TUMH_SIG_ANS_CHG);
			if (rx_acc) begin
				case (RX_SIGNAL_I)
					`TUMH_SIG_ACM: begin
						CHARGE_REC_O   <= 2'h0;
						COIN_STATION_O <= 1'b0;
					end
					`TUMH_SIG_ACM_CHG: begin
						CHARGE_REC_O   <= 2'h1;
						COIN_STATION_O <= 1'b0;
					end
					`TUMH_SIG_ACM_NOCHG: begin
						CHARGE_REC_O   <= 2'h2;
						COIN_STATION_O <= 1'b0;
					end
					`TUMH_SIG_ACM_COIN: begin
						CHARGE_REC_O   <= 2'h1;
						COIN_STATION_O <= 1'b1;
					end
					default: begin
						CHARGE_REC_O   <= CHARGE_REC_O;
						COIN_STATION_O <= COIN_STATION_O;
					end
				endcase
			end
		end
	end

	// Circuit query, registered
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			QRY_OUT_FREE_O <= 1'b0;
			QRY_IN_OK_O    <= 1'b0;
			QRY_IDLE_O     <= 1'b0;
		end else begin
			QRY_OUT_FREE_O <= idle[QRY_CIRCUIT_I] && !rem_blk[QRY_CIRCUIT_I] &&
				!loc_blk[QRY_CIRCUIT_I];
			QRY_IN_OK_O    <= idle[QRY_CIRCUIT_I] && !loc_blk[QRY_CIRCUIT_I];
			QRY_IDLE_O     <= idle[QRY_CIRCUIT_I];
		end
	end

	// Register slave and counters
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			ctrl        <= `TUMH_CTRL_RESET;
			disc_cnt    <= 8'h00;
			fmt_cnt     <= 8'h00;
			REG_RDATA_O <= 8'h00;
		end else begin
			if (REG_WR_I && REG_ADDR_I == `TUMH_REG_CTRL)
				ctrl <= REG_WDATA_I;
			// Counters saturate; a write to the count register clears them, but a count in the same cycle takes precedence
			if (rx_disc && disc_cnt != 8'hff)
				disc_cnt <= disc_cnt + 8'h01;
			else if (REG_WR_I && REG_ADDR_I == `TUMH_REG_COUNT)
				disc_cnt <= 8'h00;
			if (rx_fmt && fmt_cnt != 8'hff)
				fmt_cnt <= fmt_cnt + 8'h01;
			else if (REG_WR_I && REG_ADDR_I == `TUMH_REG_COUNT)
				fmt_cnt <= 8'h00;
			if (REG_RD_I) begin
				case (REG_ADDR_I)
					`TUMH_REG_CTRL:   REG_RDATA_O <= ctrl;
					`TUMH_REG_STATUS: REG_RDATA_O <= {resp_pend, COIN_STATION_O,
						CHARGE_REC_O, digit_cnt};
					`TUMH_REG_COUNT:  REG_RDATA_O <= {fmt_cnt[3:0], disc_cnt[3:0]};
					default:          REG_RDATA_O <= 8'h00;
				endcase
			end else begin
				REG_RDATA_O <= 8'h00;
			end
		end
	end

endmodule // tumh_msg_handler

//--- tumh_msg_handler_sva.sv
`timescale 1ns/1ns
`include "tumh_regs.vh"
module tumh_chk (
	input wire       SYS_CLK_I,
	input wire       RST_N_I,
	input wire       RX_VALID_I,
	input wire       RX_READY_O,
	input wire       RX_MSU_I,
	input wire [7:0] RX_SIO_I,
	input wire [7:0] RX_SIGNAL_I,
	input wire       RX_OCTETS_OK_I,
	input wire       RX_MAND_OK_I,
	input wire       CMD_VALID_I,
	input wire       CMD_READY_O,
	input wire [1:0] CMD_CODE_I,
	input wire [1:0] CMD_CAUSE_I,
	input wire       TX_VALID_O,
	input wire [7:0] TX_SIO_O,
	input wire [7:0] TX_SIGNAL_O,
	input wire       TX_SER_O,
	input wire       TX_SER_VALID_O,
	input wire       METER_START_O,
	input wire       DURATION_START_O
);
	// Accepted transfers and well formed messages
	wire rx_tk  = RX_VALID_I && RX_READY_O;
	wire rx_ok  = rx_tk && RX_MSU_I && RX_SIO_I[3:0] == `TUMH_SI_TUP && !RX_SIO_I[6]
		&& RX_SIO_I[5:4] == `TUMH_SPARE_VAL && RX_OCTETS_OK_I && RX_MAND_OK_I;
	wire chg_tk = rx_ok && RX_SIGNAL_I == `TUMH_SIG_ANS_CHG;
	wire cmd_tk = CMD_VALID_I && CMD_READY_O;
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	property p_si; TX_VALID_O |-> TX_SIO_O[3:0] == `TUMH_SI_TUP; endproperty
	a_si: assert property (p_si) else $error("bad service indicator");
	property p_ni; TX_VALID_O |-> !TX_SIO_O[6]; endproperty
	a_ni: assert property (p_ni) else $error("bad national indicator");
	property p_sp; TX_VALID_O |-> TX_SIO_O[5:4] == `TUMH_SPARE_VAL; endproperty
	a_sp: assert property (p_sp) else $error("spare bits not zero");
	property p_len; TX_VALID_O |=> TX_SER_VALID_O[*8] ##1 TX_SER_VALID_O[*8]; endproperty
	a_len: assert property (p_len) else $error("serial frame short");
	property p_lsb;
		TX_VALID_O |=> TX_SER_O == TX_SIO_O[0] ##8 TX_SER_O == TX_SIGNAL_O[0];
	endproperty
	a_lsb: assert property (p_lsb) else $error("serial bit order");
	property p_drop; rx_tk && (!RX_MSU_I || RX_SIO_I[3:0] != `TUMH_SI_TUP) |=> !TX_VALID_O;
	endproperty
	a_drop: assert property (p_drop) else $error("discarded message answered");
	property p_bla;
		rx_ok && RX_SIGNAL_I == `TUMH_SIG_BLO |-> ##[2:19] TX_VALID_O && TX_SIGNAL_O == `TUMH_SIG_BLA;
	endproperty
	a_bla: assert property (p_bla) else $error("no blocking ack");
	property p_uba;
		rx_ok && RX_SIGNAL_I == `TUMH_SIG_UBL |-> ##[2:19] TX_VALID_O && TX_SIGNAL_O == `TUMH_SIG_UBA;
	endproperty
	a_uba: assert property (p_uba) else $error("no unblocking ack");
	property p_mtr; METER_START_O |-> DURATION_START_O && $past(chg_tk); endproperty
	a_mtr: assert property (p_mtr) else $error("metering without charge answer");
	property p_noc; rx_tk && RX_SIGNAL_I == `TUMH_SIG_ANS_NOCHG |=> !METER_START_O; endproperty
	a_noc: assert property (p_noc) else $error("metering on no-charge answer");
	property p_clf;
		cmd_tk && CMD_CODE_I == `TUMH_CMD_CLEAR |=> TX_VALID_O && TX_SIGNAL_O == `TUMH_SIG_CLF;
	endproperty
	a_clf: assert property (p_clf) else $error("clear-forward not sent");
	property p_ssb; cmd_tk && CMD_CODE_I == `TUMH_CMD_FAIL && CMD_CAUSE_I != `TUMH_CAUSE_NATCONG
		|=> TX_SIGNAL_O == `TUMH_SIG_SSB; endproperty
	a_ssb: assert property (p_ssb) else $error("busy not sent");
endmodule // tumh_chk

bind tumh_msg_handler tumh_chk u_chk (.*);

//--- tumh_peer.sv
`timescale 1ns/1ns
module tumh_peer (
	input  wire        clk_i,
	input  wire        rdy_i,
	input  wire        ser_i,
	input  wire        ser_vld_i,
	output reg         vld_o,
	output reg         msu_o,
	output reg  [7:0]  sio_o,
	output reg  [7:0]  sig_o,
	output reg  [4:0]  circ_o,
	output reg  [1:0]  ok_o
);
	reg     [15:0] frm = 16'h0000;
	integer        hung = 0;
	// Idle lines at time zero
	initial begin
		vld_o = 1'b0;
		msu_o = 1'b0;
		sio_o = 8'h00;
		sig_o = 8'h00;
		circ_o = 5'h00;
		ok_o = 2'h0;
	end
	// Offer one message, hold until taken or 60 cycles pass, then scramble the released lines
	task send(input [7:0] s, input [7:0] g, input [4:0] c, input m, input [1:0] k);
		integer n;
		begin
			@(posedge clk_i);
			vld_o <= 1'b1;
			msu_o <= m;
			sio_o <= s;
			sig_o <= g;
			circ_o <= c;
			ok_o <= k;
			n = 0;
			@(negedge clk_i);
			while (rdy_i !== 1'b1 && n < 60) begin
				@(negedge clk_i);
				n = n + 1;
			end
			if (n == 60)
				hung = hung + 1;
			@(posedge clk_i);
			vld_o <= 1'b0;
			sio_o <= ~s;
			sig_o <= ~g;
			circ_o <= ~c;
		end
	endtask
	// Collect the serial frame, first bit ends at the bottom
	always @(posedge clk_i)
		if (ser_vld_i)
			frm <= {ser_i, frm[15:1]};
endmodule // tumh_peer

//--- tb_top.sv
`timescale 1ns/1ns
`include "tumh_regs.vh"
module tb_top;
	reg        clk = 1'b0;
	reg        rst_n = 1'b0;
	reg  [1:0] addr = 2'h0;
	reg  [7:0] wdata = 8'h00;
	reg        wr = 1'b0;
	reg        rd = 1'b0;
	reg        cv = 1'b0;
	reg  [1:0] code = 2'h0;
	reg  [1:0] cause = 2'h0;
	reg  [4:0] cc = 5'h00;
	reg  [4:0] qc = 5'h00;
	wire [7:0] rdata, tsio, tsig, psio, psig;
	wire [4:0] pcirc, tcirc;
	wire [1:0] pok, chg;
	wire       rrdy, crdy, tv, ser, sv, pv, pmsu, ofree, inok, idle, mtr, dur, coin;
	integer    mismatches = 0;
	integer    samples_checked = 0;
	// Clock
	initial forever #20 clk = ~clk;
	tumh_msg_handler #(.NCIRC(32), .CW(5), .DIGIT_TO_CYC(20)) dut (
		.SYS_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .RX_VALID_I(pv),
		.RX_READY_O(rrdy), .RX_MSU_I(pmsu), .RX_SIO_I(psio), .RX_SIGNAL_I(psig),
		.RX_CIRCUIT_I(pcirc), .RX_OCTETS_OK_I(pok[1]), .RX_MAND_OK_I(pok[0]),
		.CMD_VALID_I(cv), .CMD_READY_O(crdy), .CMD_CODE_I(code), .CMD_CAUSE_I(cause),
		.CMD_CIRCUIT_I(cc), .TX_VALID_O(tv), .TX_SIO_O(tsio), .TX_SIGNAL_O(tsig),
		.TX_CIRCUIT_O(tcirc), .TX_SER_O(ser), .TX_SER_VALID_O(sv), .QRY_CIRCUIT_I(qc),
		.QRY_OUT_FREE_O(ofree), .QRY_IN_OK_O(inok), .QRY_IDLE_O(idle),
		.METER_START_O(mtr), .DURATION_START_O(dur), .CHARGE_REC_O(chg),
		.COIN_STATION_O(coin));
	tumh_peer peer (.clk_i(clk), .rdy_i(rrdy), .ser_i(ser), .ser_vld_i(sv), .vld_o(pv),
		.msu_o(pmsu), .sio_o(psio), .sig_o(psig), .circ_o(pcirc), .ok_o(pok));
	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", samples_checked, mismatches);
			if (mismatches == 0 && samples_checked > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task chk(input [15:0] g, input [15:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("BAD %0t got %h want %h", $time, g, e);
			end
		end
	endtask
	task give_up;
		begin
			mismatches = mismatches + 1;
			$display("BAD %0t wait ran out", $time);
			report_and_stop;
		end
	endtask
	task wreg(input [1:0] a, input [7:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	// Read data is looked at in the cycle after the strobe
	task rreg(input [1:0] a, input [7:0] e);
		begin
			@(posedge clk);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			@(negedge clk);
			chk(rdata, e);
		end
	endtask
	task cmd(input [1:0] k, input [1:0] u, input [4:0] c);
		integer n;
		begin
			@(posedge clk);
			cv <= 1'b1;
			code <= k;
			cause <= u;
			cc <= c;
			n = 0;
			@(negedge clk);
			while (crdy !== 1'b1 && n < 60) begin
				@(negedge clk);
				n = n + 1;
			end
			if (n == 60)
				give_up;
			@(posedge clk);
			cv <= 1'b0;
		end
	endtask
	// Wait for one outgoing message, then for its whole serial frame
	task wait_tx(input [7:0] s, input [7:0] o);
		integer n;
		begin
			n = 0;
			@(negedge clk);
			while (tv !== 1'b1 && n < 40) begin
				@(negedge clk);
				n = n + 1;
			end
			if (n == 40)
				give_up;
			chk({tsig, tsio}, {s, o});
			repeat (17) @(negedge clk);
			chk(peer.frm, {s, o});
		end
	endtask
	task no_tx;
		integer n;
		begin
			for (n = 0; n < 30; n = n + 1) begin
				@(negedge clk);
				chk(tv, 1'b0);
			end
		end
	endtask
	task qry(input [4:0] c);
		begin
			@(posedge clk);
			qc <= c;
			@(posedge clk);
			@(negedge clk);
		end
	endtask
	task t_regs;
		begin
			rreg(`TUMH_REG_CTRL, `TUMH_CTRL_RESET);
			rreg(`TUMH_REG_COUNT, 8'h00);
			wreg(2'h3, 8'hff);
			rreg(2'h3, 8'h00);
		end
	endtask
	task t_disc;
		begin
			peer.send(8'h03, `TUMH_SIG_BLO, 5'd7, 1'b1, 2'h3);
			peer.send(8'h44, `TUMH_SIG_BLO, 5'd7, 1'b1, 2'h3);
			peer.send(8'hc4, `TUMH_SIG_BLO, 5'd7, 1'b1, 2'h3);
			peer.send(8'h14, `TUMH_SIG_BLO, 5'd7, 1'b1, 2'h3);
			peer.send(8'h04, `TUMH_SIG_BLO, 5'd7, 1'b1, 2'h1);
			peer.send(8'h04, `TUMH_SIG_BLO, 5'd7, 1'b1, 2'h2);
			peer.send(8'h04, `TUMH_SIG_BLO, 5'd7, 1'b0, 2'h3);
			no_tx;
			qry(5'd7);
			chk(ofree, 1'b1);
			rreg(`TUMH_REG_COUNT, 8'h33);
			wreg(`TUMH_REG_COUNT, 8'h00);
			rreg(`TUMH_REG_COUNT, 8'h00);
		end
	endtask
	task t_sup;
		begin
			peer.send(8'h04, `TUMH_SIG_BLO, 5'd3, 1'b1, 2'h3);
			wait_tx(`TUMH_SIG_BLA, 8'h04);
			chk(tcirc, 5'd3);
			qry(5'd3);
			chk({ofree, inok}, 2'b01);
			peer.send(8'h04, `TUMH_SIG_UBL, 5'd3, 1'b1, 2'h3);
			wait_tx(`TUMH_SIG_UBA, 8'h04);
			qry(5'd3);
			chk({ofree, inok}, 2'b11);
			cmd(`TUMH_CMD_BLOCK, 2'h0, 5'd5);
			wait_tx(`TUMH_SIG_BLO, 8'h04);
			chk(tcirc, 5'd5);
			qry(5'd5);
			chk(inok, 1'b0);
			cmd(`TUMH_CMD_UNBLOCK, 2'h0, 5'd5);
			wait_tx(`TUMH_SIG_UBL, 8'h04);
		end
	endtask
	// Reset-circuit on a locally blocked circuit under each reply mode
	task t_rsc;
		integer m;
		reg [7:0] e;
		begin
			for (m = 0; m < 3; m = m + 1) begin
				wreg(`TUMH_REG_CTRL, {3'h1, 1'b1, m[1:0], 2'h0});
				cmd(`TUMH_CMD_BLOCK, 2'h0, 5'd5);
				wait_tx(`TUMH_SIG_BLO, 8'h04);
				peer.send(8'h04, `TUMH_SIG_RSC, 5'd5, 1'b1, 2'h3);
				e = m == 0 ? `TUMH_SIG_RLG : m == 1 ? `TUMH_SIG_CLF : `TUMH_SIG_BLO;
				wait_tx(e, 8'h04);
				qry(5'd5);
				chk(inok, m != 2);
			end
			// Seizure on the locally blocked circuit is refused and counted
			peer.send(8'h04, `TUMH_SIG_DIGIT, 5'd5, 1'b1, 2'h3);
			rreg(`TUMH_REG_COUNT, 8'h01);
		end
	endtask
	task t_call;
		integer i;
		begin
			peer.send(8'h04, `TUMH_SIG_CLF, 5'd9, 1'b1, 2'h3);
			wait_tx(`TUMH_SIG_RLG, 8'h04);
			qry(5'd9);
			chk(idle, 1'b1);
			peer.send(8'h04, `TUMH_SIG_ANS_CHG, 5'd9, 1'b1, 2'h3);
			@(negedge clk);
			chk({mtr, dur}, 2'b11);
			peer.send(8'h04, `TUMH_SIG_ANS_NOCHG, 5'd9, 1'b1, 2'h3);
			@(negedge clk);
			chk(mtr, 1'b0);
			for (i = 0; i < 4; i = i + 1) begin
				peer.send(8'h04, `TUMH_SIG_ACM + i[7:0], 5'd9, 1'b1, 2'h3);
				@(negedge clk);
				chk({chg, coin}, i == 0 ? 3'h0 : i == 1 ? 3'h2 : i == 2 ? 3'h4 : 3'h3);
			end
			rreg(`TUMH_REG_STATUS, 8'h50);
			for (i = 0; i < 4; i = i + 1) begin
				cmd(`TUMH_CMD_FAIL, i[1:0], 5'd9);
				wait_tx(i == 3 ? `TUMH_SIG_NNC : `TUMH_SIG_SSB, 8'h04);
			end
			cmd(`TUMH_CMD_CLEAR, 2'h0, 5'd9);
			wait_tx(`TUMH_SIG_CLF, 8'h04);
		end
	endtask
	// Minimum two digits, national messages
	task t_digits;
		begin
			wreg(`TUMH_REG_CTRL, 8'h56);
			peer.send(8'h84, `TUMH_SIG_DIGIT, 5'd2, 1'b1, 2'h3);
			peer.send(8'h84, `TUMH_SIG_DIGIT, 5'd2, 1'b1, 2'h3);
			peer.send(8'h84, `TUMH_SIG_EOA, 5'd2, 1'b1, 2'h3);
			no_tx;
			peer.send(8'h84, `TUMH_SIG_DIGIT, 5'd2, 1'b1, 2'h3);
			peer.send(8'h84, `TUMH_SIG_EOA, 5'd2, 1'b1, 2'h3);
			wait_tx(`TUMH_SIG_ADI, 8'h84);
			peer.send(8'h84, `TUMH_SIG_DIGIT, 5'd2, 1'b1, 2'h3);
			wait_tx(`TUMH_SIG_ADI, 8'h84);
			chk(tcirc, 5'd2);
		end
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_disc;
		t_sup;
		t_rsc;
		t_call;
		t_digits;
		chk(peer.hung[15:0], 16'h0000);
		report_and_stop;
	end
endmodule // tb_top
